// ===== rtl/host_sector_consts.svh
`ifndef HOST_SECTOR_CONSTS_SVH
`define HOST_SECTOR_CONSTS_SVH

// ****************************************
// Host port address map
// ****************************************
`define HSC_ADDR_W        7
`define HSC_LBA_OFS       7'h10
`define HSC_CNT_OFS       7'h14

// ****************************************
// Field layout
// ****************************************
`define HSC_LBA_W         28
`define HSC_CNT_LSB       0
`define HSC_CNT_W         8
`define HSC_CMD_LSB       8
`define HSC_CMD_W         3
`define HSC_SECT_W        9
`define HSC_SECTOR_SHIFT  9
`define HSC_OFS_W         37
`define HSC_MAX_SECTORS   9'h100

// ****************************************
// Command codes
// ****************************************
`define HSC_CMD_NONE      3'h0
`define HSC_CMD_RESET     3'h1
`define HSC_CMD_IDENTIFY  3'h2
`define HSC_CMD_READ      3'h3
`define HSC_CMD_WRITE     3'h4
`define HSC_CMD_RSVD5     3'h5
`define HSC_CMD_ABORT     3'h6
`define HSC_CMD_RSVD7     3'h7

// ****************************************
// Reset values
// ****************************************
`define HSC_LBA_RST       28'h0000000
`define HSC_CNT_RST       8'h00
`define HSC_CMD_RST       3'h0

`endif

// ===== rtl/host_sector_pkg.sv
`include "host_sector_consts.svh"

package host_sector_pkg;

    // Host register request, one cycle per access
    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [`HSC_ADDR_W-1:0] addr;
        logic [31:0]            wdata;
    } host_req_s;

    // Command handed to the card controller
    typedef struct packed {
        logic                   issue;
        logic                   abort;
        logic [`HSC_CMD_W-1:0]  code;
        logic [`HSC_LBA_W-1:0]  lba;
        logic [`HSC_SECT_W-1:0] sectors;
    } card_cmd_s;

    // Whole state of the front end
    typedef struct packed {
        logic [`HSC_LBA_W-1:0]  lba;
        logic [`HSC_CNT_W-1:0]  count;
        logic [`HSC_CMD_W-1:0]  cmd;
        card_cmd_s              card;
        logic [31:0]            rdata;
        logic                   rvalid;
    } state_s;

endpackage

// ===== rtl/host_sector_command_regs.sv
// Operation
// - Host reads and writes a 28-bit block address in bits 27:0.
// - Host block address drives host transfers only, never configuration address.
// - Each block address selects one 512-byte sector.
// - Sector count sits in bits 7:0, counting 512-byte sectors.
// - Count 1 to 255 transfers exactly that many sectors.
// - Count zero transfers 256 sectors.
// - Without the lock, command field writes are ignored, nothing starts.
// - With the lock, codes 1 to 4 and 6 are stored and executed; reserved codes 5 and 7 are ignored.
// - With the lock, writing zero leaves the command field unchanged.
// - Abort code 6 terminates the card command; controller then clears field.
// - Command field bits 10:8; code 1 resets card, code 2 identifies.
// - Code 3 reads, code 4 writes sectors from block address for count.
`timescale 1ns/1ps
`include "host_sector_consts.svh"

module host_sector_command_regs
    import host_sector_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_b,
    input  wire logic                   i_ce,
    input  wire host_req_s              i_host_req,
    input  wire logic                   i_lock_granted,
    input  wire logic                   i_card_cmd_clear,
    output logic [31:0]                 o_host_rdata,
    output logic                        o_host_rvalid,
    output card_cmd_s                   o_card,
    output logic [`HSC_OFS_W-1:0]       o_card_byte_offset,
    output logic [`HSC_CMD_W-1:0]       o_cmd_field
);

    // ****************************************
    // Helper functions
    // ****************************************

    // Count field to number of sectors
    function automatic logic [`HSC_SECT_W-1:0] sector_total(input logic [`HSC_CNT_W-1:0] cnt);
        if (cnt == `HSC_CNT_W'(0))
            sector_total = `HSC_MAX_SECTORS;
        else
            sector_total = {1'b0, cnt};
    endfunction

    // Code that starts a card operation
    function automatic logic code_starts(input logic [`HSC_CMD_W-1:0] code);
        case (code)
            `HSC_CMD_RESET, `HSC_CMD_IDENTIFY,
            `HSC_CMD_READ, `HSC_CMD_WRITE,
            `HSC_CMD_ABORT: code_starts = 1'b1;
            default:        code_starts = 1'b0;
        endcase
    endfunction

    // ****************************************
    // State
    // ****************************************
    state_s                 st_reg;
    state_s                 st_next;
    logic                   wr_lba;
    logic                   wr_cnt;
    logic [`HSC_CMD_W-1:0]  wr_code;
    logic [`HSC_CNT_W-1:0]  wr_count;

    // Write decode
    assign wr_lba   = i_host_req.wr && (i_host_req.addr == `HSC_LBA_OFS);
    assign wr_cnt   = i_host_req.wr && (i_host_req.addr == `HSC_CNT_OFS);
    assign wr_code  = i_host_req.wdata[`HSC_CMD_LSB +: `HSC_CMD_W];
    assign wr_count = i_host_req.wdata[`HSC_CNT_LSB +: `HSC_CNT_W];

    // Next state
    always_comb
    begin
        st_next = st_reg;
        if (i_ce)
        begin
            st_next.card.issue = 1'b0;
            st_next.card.abort = 1'b0;
            st_next.rvalid     = 1'b0;
            // Controller clears the field once abort has finished
            if (i_card_cmd_clear && st_reg.cmd == `HSC_CMD_ABORT)
                st_next.cmd = `HSC_CMD_NONE;
            if (wr_lba)
                st_next.lba = i_host_req.wdata[`HSC_LBA_W-1:0];
            if (wr_cnt)
            begin
                st_next.count = wr_count;
                // Locked nonzero valid code wins over the clear
                if (i_lock_granted && code_starts(wr_code))
                begin
                    st_next.cmd       = wr_code;
                    st_next.card.code = wr_code;
                    if (wr_code == `HSC_CMD_ABORT)
                        st_next.card.abort = 1'b1;
                    else
                    begin
                        st_next.card.issue   = 1'b1;
                        st_next.card.lba     = st_reg.lba;
                        st_next.card.sectors = sector_total(wr_count);
                    end
                end
            end
            // Read return, reserved bits zero
            if (i_host_req.rd)
            begin
                st_next.rvalid = 1'b1;
                st_next.rdata  = 32'h00000000;
                if (i_host_req.addr == `HSC_LBA_OFS)
                    st_next.rdata[`HSC_LBA_W-1:0] = st_reg.lba;
                else if (i_host_req.addr == `HSC_CNT_OFS)
                begin
                    st_next.rdata[`HSC_CNT_LSB +: `HSC_CNT_W] = st_reg.count;
                    st_next.rdata[`HSC_CMD_LSB +: `HSC_CMD_W] = st_reg.cmd;
                end
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_host_rdata       = st_reg.rdata;
    assign o_host_rvalid      = st_reg.rvalid;
    assign o_card             = st_reg.card;
    assign o_cmd_field        = st_reg.cmd;
    // Byte position of the sector on the card
    assign o_card_byte_offset = {st_reg.card.lba, `HSC_SECTOR_SHIFT'(0)};

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Block address write lands in the register
    chk_lba_store: assert property (
        i_ce && wr_lba
        |=> st_reg.lba == $past(i_host_req.wdata[27:0]))
        else $error("block address not stored");

    // Block address reads back with top bits zero
    chk_lba_readback: assert property (
        i_ce && i_host_req.rd && i_host_req.addr == `HSC_LBA_OFS
        |=> o_host_rvalid && o_host_rdata == {4'h0, $past(st_reg.lba)})
        else $error("block address readback wrong");

    // Address write alone never moves the card address
    chk_lba_latched: assert property (
        i_ce && wr_lba && !(wr_cnt && i_lock_granted)
        |=> $stable(o_card.lba))
        else $error("command address moved without a command");

    // Card address only ever comes from the host register
    chk_host_only: assert property (
        o_card.issue
        |-> o_card.lba == $past(st_reg.lba))
        else $error("card address not from host register");

    // Sector byte position is the block address times 512
    chk_byte_offset: assert property (
        o_card_byte_offset == {9'h000, o_card.lba} * 37'h200)
        else $error("sector byte offset wrong");

    // Count and command read back, reserved bits zero
    chk_cnt_readback: assert property (
        i_ce && i_host_req.rd && i_host_req.addr == `HSC_CNT_OFS
        |=> o_host_rdata == {21'h000000, $past(st_reg.cmd), $past(st_reg.count)})
        else $error("count and command readback wrong");

    // Unmapped reads return zero
    chk_unmapped_read: assert property (
        i_ce && i_host_req.rd && i_host_req.addr != `HSC_LBA_OFS && i_host_req.addr != `HSC_CNT_OFS
        |=> o_host_rdata == 32'h00000000)
        else $error("unmapped read not zero");

    // Read valid is a single pulse
    chk_rvalid_pulse: assert property (
        i_ce && !i_host_req.rd
        |=> !o_host_rvalid)
        else $error("read valid without a read");

    // Read data holds until the next read
    chk_rdata_hold: assert property (
        !(i_ce && i_host_req.rd)
        |=> $stable(o_host_rdata))
        else $error("read data moved without a read");

    // Count 1 to 255 gives exactly that many sectors
    chk_count_exact: assert property (
        i_ce && wr_cnt && i_lock_granted && wr_count != 8'h00 && (wr_code == 3'h3 || wr_code == 3'h4)
        |=> o_card.issue && o_card.sectors == {1'b0, $past(wr_count)})
        else $error("sector span wrong");

    // Count zero means 256 sectors
    chk_count_zero: assert property (
        i_ce && wr_cnt && i_lock_granted && wr_count == 8'h00 && wr_code == 3'h3
        |=> o_card.sectors == 9'h100)
        else $error("zero count not 256");

    // Issued span always within 1 to 256
    chk_sectors_range: assert property (
        o_card.issue
        |-> o_card.sectors != 9'h000 && o_card.sectors <= 9'h100)
        else $error("issued span out of range");

    // No lock, no command
    chk_no_lock: assert property (
        i_ce && wr_cnt && !i_lock_granted && !i_card_cmd_clear
        |=> $stable(st_reg.cmd) && !o_card.issue && !o_card.abort)
        else $error("command taken without lock");

    // Locked valid code is stored and issued once
    chk_cmd_issue: assert property (
        i_ce && wr_cnt && i_lock_granted && wr_code inside {3'h1, 3'h2, 3'h3, 3'h4}
        |=> o_card.issue && o_card.code == $past(wr_code) && o_cmd_field == $past(wr_code)
        ##1 (!o_card.issue || !$past(i_ce) || $past(i_ce && wr_cnt && i_lock_granted)))
        else $error("command not issued once");

    // Pulses only follow a locked command write
    chk_issue_pulse: assert property (
        i_ce && !(wr_cnt && i_lock_granted)
        |=> !o_card.issue && !o_card.abort)
        else $error("card pulse without a command");

    // Zero code leaves the field alone
    chk_zero_keep: assert property (
        i_ce && wr_cnt && wr_code == 3'h0 && !i_card_cmd_clear
        |=> $stable(st_reg.cmd))
        else $error("zero write changed command");

    // Field moves only on a command or a clear
    chk_field_steady: assert property (
        i_ce && !i_card_cmd_clear && !(wr_cnt && i_lock_granted)
        |=> $stable(o_cmd_field))
        else $error("command field moved by itself");

    // Abort is signalled and stored
    chk_abort_seq: assert property (
        i_ce && wr_cnt && i_lock_granted && wr_code == 3'h6
        |=> o_card.abort && !o_card.issue && o_cmd_field == 3'h6)
        else $error("abort not signalled");

    // Abort leaves the latched address and span alone
    chk_abort_keep: assert property (
        i_ce && wr_cnt && i_lock_granted && wr_code == 3'h6
        |=> $stable(o_card.lba) && $stable(o_card.sectors))
        else $error("abort changed command address");

    // Controller clear empties the field after abort
    chk_abort_clear: assert property (
        i_ce && i_card_cmd_clear && st_reg.cmd == 3'h6 && !wr_cnt
        |=> o_cmd_field == 3'h0)
        else $error("abort did not clear command");

    // Clear outside abort is ignored
    chk_clear_ignored: assert property (
        i_ce && i_card_cmd_clear && st_reg.cmd != 3'h6 && !(wr_cnt && i_lock_granted)
        |=> $stable(o_cmd_field))
        else $error("clear honoured outside abort");

    // Field never holds a reserved code
    chk_field_legal: assert property (
        o_cmd_field != 3'h5 && o_cmd_field != 3'h7)
        else $error("reserved code stored");

    // Reserved codes start nothing
    chk_reserved: assert property (
        i_ce && wr_cnt && wr_code inside {3'h5, 3'h7}
        |=> !o_card.issue && !o_card.abort)
        else $error("reserved code started operation");

    // Card code and span hold between commands
    chk_code_hold: assert property (
        i_ce && !(wr_cnt && i_lock_granted)
        |=> $stable(o_card.code) && $stable(o_card.sectors))
        else $error("card command moved without a command");

    // Count written regardless of lock
    chk_count_open: assert property (
        i_ce && wr_cnt
        |=> st_reg.count == $past(wr_count))
        else $error("count not written");

    // Sector read starts at the held block address
    chk_read_lba: assert property (
        i_ce && wr_cnt && i_lock_granted && wr_code == 3'h3 && !wr_lba
        |=> o_card.lba == $past(st_reg.lba))
        else $error("read started at wrong block");

    // Clock enable low freezes all state
    chk_ce_freeze: assert property (
        !i_ce
        |=> st_reg == $past(st_reg))
        else $error("state moved while frozen");

endmodule

// ===== verif/host_cpu_model.sv
`timescale 1ns/1ps

module host_cpu_model
    import host_sector_pkg::*;
(
    input  wire logic      i_clk,
    output host_req_s      o_req
);
    initial o_req = '0;

    // One word access, held over exactly one taking edge
    task automatic access(input logic wr, input logic [6:0] addr, input logic [31:0] data);
        @(posedge i_clk);
        #1;
        o_req = {wr, !wr, addr, data};
        @(posedge i_clk);
        #1;
        o_req = '0;
    endtask
endmodule

// ===== verif/host_sector_command_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s expected %0h seen %0h", n, e, g); end end

module host_sector_command_regs_tb_top
    import host_sector_pkg::*;
;
    logic                    clk;
    logic                    rst_b;
    logic                    lock;
    logic                    clr;
    logic                    ce;
    host_req_s               req;
    logic [31:0]             rdata;
    logic                    rvalid;
    card_cmd_s               card;
    logic [36:0]             ofs;
    logic [2:0]              field;
    int                      fail_count;
    int                      samples_checked;
    int                      m_lba;
    int                      m_cnt;
    int                      m_cmd;
    int                      k;

    host_cpu_model u_host (.i_clk(clk), .o_req(req));

    host_sector_command_regs u_dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_host_req(req), .i_lock_granted(lock),
        .i_card_cmd_clear(clr), .o_host_rdata(rdata), .o_host_rvalid(rvalid), .o_card(card),
        .o_card_byte_offset(ofs), .o_cmd_field(field));

    // ****************************************
    // Reference model and comparisons
    // ****************************************
    task automatic op(input logic wr, input logic [6:0] a, input logic [31:0] d);
        int c;
        int go;
        int ab;
        u_host.access(wr, a, d);
        c = d[10:8];
        if (ce && wr && a == 7'h10) m_lba = d[27:0];
        if (wr && a == 7'h14)
        begin
            if (ce) m_cnt = d[7:0];
            go = ce && lock && c >= 1 && c <= 4;
            ab = ce && lock && c == 6;
            if (go || ab) m_cmd = c;
            `CHK("issue", go[0], card.issue)
            `CHK("abort", ab[0], card.abort)
            if (go)
            begin
                `CHK("sectors", (m_cnt == 0) ? 9'h100 : 9'(m_cnt), card.sectors)
                `CHK("code", 3'(c), card.code)
                `CHK("lba", 28'(m_lba), card.lba)
                `CHK("offset", {28'(m_lba), 9'h000}, ofs)
            end
        end
        if (!wr)
        begin
            `CHK("rvalid", 1'b1, rvalid)
            `CHK("rdata", (a == 7'h10) ? 32'(m_lba) : (a == 7'h14) ? 32'(m_cmd * 256 + m_cnt) : 32'h0, rdata)
        end
        `CHK("field", 3'(m_cmd), field)
    endtask

    // Card controller finishing an abort
    task automatic clear_pulse;
        @(posedge clk);
        #1;
        clr = 1'b1;
        @(posedge clk);
        #1;
        clr = 1'b0;
        if (m_cmd == 6) m_cmd = 0;
        `CHK("field", 3'(m_cmd), field)
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Clock at 200 MHz
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard
    initial
    begin
        #20000;
        fail_count++;
        end_of_test;
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        {rst_b, lock, clr, fail_count, samples_checked, m_lba, m_cnt, m_cmd} = '0;
        ce = 1'b1;
        k = $urandom(44882);
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        op(1'b0, 7'h10, 32'h0);
        op(1'b0, 7'h14, 32'h0);
        $display("test reset_values done");
        lock = 1'b1;
        op(1'b1, 7'h10, 32'hFFFFFFFF);
        for (k = 0; k < 8; k++)
        begin
            op(1'b1, 7'h14, (k << 8) | ((k == 3) ? 0 : (k == 4) ? 255 : $urandom % 256));
            op(1'b1, 7'h14, 32'h00000000);
            op(1'b0, 7'h14, 32'h0);
            op(1'b1, 7'h14, 32'h00000600);
            clear_pulse();
        end
        $display("test all_codes done");
        lock = 1'b0;
        op(1'b1, 7'h14, 32'h00000312);
        op(1'b1, 7'h14, 32'h00000600);
        $display("test unlocked done");
        // Frozen writes must leave every register alone
        ce = 1'b0;
        lock = 1'b1;
        op(1'b1, 7'h10, 32'h00ABCDEF);
        op(1'b1, 7'h14, 32'h00000305);
        ce = 1'b1;
        op(1'b0, 7'h10, 32'h0);
        op(1'b0, 7'h14, 32'h0);
        $display("test clock_enable done");
        for (k = 0; k < 80; k++)
        begin
            lock = $urandom % 2;
            if ($urandom % 4 == 0)
                clear_pulse();
            else
                op($urandom % 2, 7'h10 + 7'h4 * 7'($urandom % 3), $urandom);
        end
        $display("test random_mix done");
        // Reset in mid-run returns everything to zero
        rst_b = 1'b0;
        @(posedge clk);
        #1;
        rst_b = 1'b1;
        {m_lba, m_cnt, m_cmd} = '0;
        op(1'b0, 7'h10, 32'h0);
        op(1'b0, 7'h14, 32'h0);
        $display("test mid_reset done");
        end_of_test;
    end
endmodule
